// ===== iss_pkg.sv
// constants and types shared by the init/sync sequencer files
package iss_pkg;

    // ****************************************************************
    // register bus
    // ****************************************************************
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 16;
    localparam logic [7:0]  OFF_RESET_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_ONESHOT_CTRL    = 8'h01;
    localparam logic [7:0]  OFF_OUT_EN_CTRL     = 8'h03;
    localparam logic [7:0]  OFF_SYNC_SELECT     = 8'h04;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] RST_RESET_CTRL      = 16'hff00;
    localparam logic [15:0] RST_ONESHOT_CTRL    = 16'h0000;
    localparam logic [15:0] RST_OUT_EN_CTRL     = 16'h0000;
    localparam logic [15:0] RST_SYNC_SELECT     = 16'h0000;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int          RESET_HOLD_LSB      = 9;    // bits 15:9, any set holds reset
    localparam int          OE_SYNC_OUT_BIT     = 8;
    localparam int          OE_DATA_W           = 8;    // bits 7:0 gate the data outputs
    localparam int          OS_LEVEL_BIT        = 3;    // level value when not in pulse form
    localparam int          OS_PULSE_BIT        = 2;
    localparam int          OS_FORCE_SO_BIT     = 4;
    localparam int          SEL_W               = 3;
    localparam int          NUM_SEL             = 5;    // so, fir, sck, nco, cic
    localparam int          SEL_SO              = 0;

    // ****************************************************************
    // documented command words
    // ****************************************************************
    localparam logic [15:0] CMD_RESET_ENTER     = 16'hff00;
    localparam logic [15:0] CMD_RESET_LEAVE     = 16'h0100;
    localparam logic [15:0] CMD_OUT_ALL_OFF     = 16'h0000;
    localparam logic [15:0] CMD_OUT_SO_ONLY     = 16'h0100;
    localparam logic [15:0] CMD_OS_PULSE        = 16'h0004;
    localparam logic [15:0] CMD_OS_PULSE_SO     = 16'h0014;

    // ****************************************************************
    // sync source codes
    // ****************************************************************
    typedef enum logic [2:0] {
        SRC_NEVER   = 3'h0,
        SRC_NEVER1  = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_SECOND  = 3'h3,
        SRC_ONESHOT = 3'h4,
        SRC_TIMER   = 3'h5,
        SRC_ALWAYS6 = 3'h6,
        SRC_ALWAYS7 = 3'h7
    } iss_src_t;

endpackage : iss_pkg

// ===== iss_sync_if.sv
// interface between the pin synchroniser and the sequencer core
`timescale 1ns/100ps
interface iss_sync_if #(
    parameter int W = 2
);
    logic [W-1:0] pin_n;
    logic [W-1:0] active;

    modport core (output pin_n, input  active);
    modport sync (input  pin_n, output active);
endinterface : iss_sync_if

// ===== iss_sync_in.sv
// three-stage synchroniser and inverter for active-low sync pins
`timescale 1ns/100ps
module iss_sync_in
    import iss_pkg::*;
#(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pins in, active-high levels out
    iss_sync_if.sync  sif
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] act_q;
    logic [W-1:0] act_d;

    if (W < 1) begin : g_bad_width
        $error("iss_sync_in: W must be at least 1");
    end

    // sources change on the device clock edge, so a one-clock repetitive
    // sync must pass: stage three is taken as it stands, no agreement filter
    assign act_d      = ~s3_q;
    assign sif.active = act_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            act_q <= '0;
        end else begin
            s1_q  <= sif.pin_n;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            act_q <= act_d;
        end
    end
endmodule : iss_sync_in

// ===== iss_init_sync_sequencer.sv
// reset, output enable and sync source control for device initialisation
//
// Functional notes
// - write ff00 to address 0 enters reset
// - write zero to address 3 disables all outputs
// - write 100 to address 3 keeps sync out
// - write 04 to address 1 selects pulse one-shot
// - write 100 to address 0 leaves reset
// - after reset, 04 to address 1 pulses one-shot
// - 14 to address 1 pulses master sync out
// - primary sync input sampled on device clock
// - both sync pins inverted to active high
`timescale 1ns/100ps
module iss_init_sync_sequencer
    import iss_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    // sync pins
    input  wire logic                primary_sync_input_n,
    input  wire logic                secondary_sync_input_n,
    output logic                     sync_out_n,
    output logic                     sync_out_oe,
    // device control
    output logic                     chip_reset,
    output logic      [OE_DATA_W-1:0] data_out_en,
    output logic      [NUM_SEL-2:0]  block_hold
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // every field below is fixed by the package; refuse a package that breaks them
    if (NUM_SEL < 2 || NUM_SEL * SEL_W > DATA_W) begin : g_bad_sel
        $error("iss_init_sync_sequencer: selector fields do not fit the register");
    end
    if (ADDR_W < 3) begin : g_bad_addr
        $error("iss_init_sync_sequencer: address too narrow for the register map");
    end
    // entering reset must set a hold bit, leaving reset must clear every hold bit
    if ((CMD_RESET_ENTER >> RESET_HOLD_LSB) == 16'h0000) begin : g_bad_enter
        $error("iss_init_sync_sequencer: entering reset sets no hold bit");
    end
    if ((CMD_RESET_LEAVE >> RESET_HOLD_LSB) != 16'h0000) begin : g_bad_leave
        $error("iss_init_sync_sequencer: leaving reset keeps a hold bit");
    end
    if (OE_DATA_W > OE_SYNC_OUT_BIT) begin : g_bad_oe
        $error("iss_init_sync_sequencer: data enables overlap the sync out enable");
    end
    if (CMD_OUT_SO_ONLY[OE_SYNC_OUT_BIT] != 1'b1) begin : g_bad_so_only
        $error("iss_init_sync_sequencer: sync-out-only command misses its enable");
    end
    if (OS_PULSE_BIT == OS_LEVEL_BIT || OS_PULSE_BIT == OS_FORCE_SO_BIT) begin : g_bad_os
        $error("iss_init_sync_sequencer: one-shot control bits overlap");
    end
    if (!CMD_OS_PULSE[OS_PULSE_BIT] || !CMD_OS_PULSE_SO[OS_FORCE_SO_BIT]) begin : g_bad_cmd
        $error("iss_init_sync_sequencer: one-shot commands miss their bits");
    end

    // ****************************************************************
    // pin synchroniser
    // ****************************************************************
    // pins show inside four clocks after they move, the outputs one clock later
    iss_sync_if #(.W(2)) sif ();

    assign sif.pin_n = {secondary_sync_input_n, primary_sync_input_n};

    iss_sync_in #(.W(2)) u_sync_in (
        .clk   (clk),
        .rst_n (rst_n),
        .sif   (sif)
    );

    wire logic primary_sync   = sif.active[0];
    wire logic secondary_sync = sif.active[1];

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [DATA_W-1:0]          reset_control_q;
    logic [DATA_W-1:0]          sync_oneshot_control_q;
    logic [DATA_W-1:0]          output_enable_control_q;
    logic [DATA_W-1:0]          sync_select_q;
    logic [DATA_W-1:0]          rdata_d;

    wire logic hit_reset   = (reg_addr == OFF_RESET_CTRL);
    wire logic hit_oneshot = (reg_addr == OFF_ONESHOT_CTRL);
    wire logic hit_out_en  = (reg_addr == OFF_OUT_EN_CTRL);
    wire logic hit_select  = (reg_addr == OFF_SYNC_SELECT);

    wire logic wr_reset   = reg_wr && hit_reset;
    wire logic wr_oneshot = reg_wr && hit_oneshot;
    wire logic wr_out_en  = reg_wr && hit_out_en;
    wire logic wr_select  = reg_wr && hit_select;

    // zero outside a read strobe, so read data stand for one cycle only;
    // unmapped addresses read as zero
    assign rdata_d = ({DATA_W{reg_rd && hit_reset}}   & reset_control_q)
                   | ({DATA_W{reg_rd && hit_oneshot}} & sync_oneshot_control_q)
                   | ({DATA_W{reg_rd && hit_out_en}}  & output_enable_control_q)
                   | ({DATA_W{reg_rd && hit_select}}  & sync_select_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_control_q         <= RST_RESET_CTRL;
            sync_oneshot_control_q  <= RST_ONESHOT_CTRL;
            output_enable_control_q <= RST_OUT_EN_CTRL;
            sync_select_q           <= RST_SYNC_SELECT;
        end else begin
            if (wr_reset) begin
                reset_control_q <= reg_wdata;
            end
            if (wr_oneshot) begin
                sync_oneshot_control_q <= reg_wdata;
            end
            if (wr_out_en) begin
                output_enable_control_q <= reg_wdata;
            end
            if (wr_select) begin
                sync_select_q <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // reset and one-shot
    // ****************************************************************
    // ff00 has upper bits set, 0100 only bit 8: the hold bits tell them apart
    wire logic reset_hold = |reset_control_q[DATA_W-1:RESET_HOLD_LSB];

    // a pulse written while reset is held only arms pulse form, it fires nothing;
    // config loaded under reset is therefore never disturbed by a stray sync
    wire logic os_fire = wr_oneshot && reg_wdata[OS_PULSE_BIT] && !reset_hold;
    wire logic os_pulse_form = sync_oneshot_control_q[OS_PULSE_BIT];

    logic os_pulse_q;
    logic os_force_q;
    wire logic oneshot = os_pulse_form ? os_pulse_q
                                       : sync_oneshot_control_q[OS_LEVEL_BIT];

    // ****************************************************************
    // sync source selection
    // ****************************************************************
    function automatic logic pick(input logic [SEL_W-1:0] sel, input logic p,
                                  input logic s, input logic os);
        logic r;
        r = 1'b0;
        case (iss_src_t'(sel))
            SRC_PRIMARY: r = p;
            SRC_SECOND:  r = s;
            SRC_ONESHOT: r = os;
            SRC_ALWAYS6: r = 1'b1;
            SRC_ALWAYS7: r = 1'b1;
            default:     r = 1'b0;
        endcase
        return r;
    endfunction : pick

    logic [NUM_SEL-1:0] sync_act;

    for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
        assign sync_act[g] = pick(sync_select_q[g*SEL_W +: SEL_W], primary_sync,
                                  secondary_sync, oneshot);
    end

    // force bit routes the one-shot to sync out, for the master's pulse
    wire logic so_act = os_force_q ? oneshot : sync_act[SEL_SO];

    // ****************************************************************
    // one-shot state
    // ****************************************************************
    // the force bit follows every address 1 write, so a plain 04 drops it again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            os_pulse_q <= 1'b0;
            os_force_q <= 1'b0;
        end else begin
            os_pulse_q <= os_fire;
            if (wr_oneshot) begin
                os_force_q <= reg_wdata[OS_FORCE_SO_BIT];
            end
        end
    end

    // ****************************************************************
    // output flops
    // ****************************************************************
    // blocks stay initialised while held, run the clock after release
    wire logic [NUM_SEL-2:0] hold_d = sync_act[NUM_SEL-1:1]
                                    | {(NUM_SEL-1){reset_hold}};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out_n  <= 1'b1;
            sync_out_oe <= 1'b0;
            chip_reset  <= 1'b1;
            data_out_en <= '0;
            block_hold  <= '0;
            reg_rdata   <= '0;
        end else begin
            sync_out_n  <= ~so_act;
            sync_out_oe <= output_enable_control_q[OE_SYNC_OUT_BIT];
            chip_reset  <= reset_hold;
            data_out_en <= output_enable_control_q[OE_DATA_W-1:0];
            block_hold  <= hold_d;
            reg_rdata   <= rdata_d;
        end
    end

endmodule : iss_init_sync_sequencer

// ===== iss_checker.sv
// port assertions for the init/sync sequencer
`timescale 1ns/100ps
module iss_checker
    import iss_pkg::*;
(
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst_n,
    // register port
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    input wire logic                 reg_wr,
    // pins and control
    input wire logic                 primary_sync_input_n,
    input wire logic                 sync_out_n,
    input wire logic                 sync_out_oe,
    input wire logic                 chip_reset,
    input wire logic [OE_DATA_W-1:0] data_out_en,
    input wire logic [NUM_SEL-2:0]   block_hold
);
    // shadow of the selectors: sync checks must know the routing
    logic [14:0] sel_q;
    wire         wr0 = reg_wr && reg_addr == 8'h00;
    wire         wr1 = reg_wr && reg_addr == 8'h01;
    wire         wr3 = reg_wr && reg_addr == 8'h03;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= 15'h0000;
        end else if (reg_wr && reg_addr == 8'h04) begin
            sel_q <= reg_wdata[14:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_enter_a:
        assert property (wr0 && reg_wdata == 16'hff00 |=> ##1 chip_reset) else $error("no reset");
    reset_leave_a:
        assert property (wr0 && reg_wdata == 16'h0100 |=> ##1 !chip_reset) else $error("stuck");
    outputs_off_a:
        assert property (wr3 && reg_wdata == 16'h0000 |=> ##1 !sync_out_oe && data_out_en == 8'h00)
        else $error("outputs left on");
    sync_only_a:
        assert property (wr3 && reg_wdata == 16'h0100 |=> ##1 sync_out_oe && data_out_en == 8'h00)
        else $error("sync out enable wrong");
    oneshot_pulse_a:
        assert property (wr1 && !chip_reset && (reg_wdata == 16'h0014 ||
            (reg_wdata == 16'h0004 && sel_q[2:0] == 3'h4)) |=> ##1 !sync_out_n ##1 sync_out_n)
        else $error("one-shot pulse wrong");
    sync_hold_a:
        assert property ((!primary_sync_input_n)[*6] ##0 sel_q[5:3] == 3'h2 |-> block_hold[0])
        else $error("hold missing");
    hold_release_a:
        assert property ((primary_sync_input_n && !chip_reset)[*6] ##0 sel_q[5:3] == 3'h2
            |-> !block_hold[0]) else $error("hold stuck");
    sync_follow_a:
        assert property ((!primary_sync_input_n)[*6] ##0 sel_q[2:0] == 3'h2 |-> !sync_out_n)
        else $error("sync out not following");
endmodule : iss_checker
bind iss_init_sync_sequencer iss_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .primary_sync_input_n, .sync_out_n, .sync_out_oe, .chip_reset, .data_out_en, .block_hold);

// ===== iss_sync_gen.sv
// host-side sync generator for the active-low sync pins
`timescale 1ns/100ps
module iss_sync_gen (
    // clock
    input  wire logic clk,
    // requests from the bench
    input  wire logic hold_low,
    input  wire logic pulse,
    // sync pins
    output logic      primary_sync_input_n,
    output logic      secondary_sync_input_n
);
    // moves only on the device clock edge so all chips see one edge
    initial primary_sync_input_n = 1'b1;
    always @(posedge clk) begin
        primary_sync_input_n <= !(hold_low || pulse);
    end
    // second pin unused; its pull-up keeps it inactive
    assign secondary_sync_input_n = 1'b1;
endmodule : iss_sync_gen

// ===== iss_init_sync_sequencer_tb.sv
// self-checking bench for the init/sync sequencer
`timescale 1ns/100ps
module iss_init_sync_sequencer_tb import iss_pkg::*;;
    logic                 clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                 hold_low = 1'b0, pulse = 1'b0;
    logic [ADDR_W-1:0]    reg_addr = 8'h00;
    logic [DATA_W-1:0]    reg_wdata = 16'h0000, reg_rdata;
    logic                 primary_sync_input_n, secondary_sync_input_n;
    logic                 sync_out_n, sync_out_oe, chip_reset;
    logic [OE_DATA_W-1:0] data_out_en;
    logic [NUM_SEL-2:0]   block_hold;
    int                   n_mismatch = 0, checks_done = 0, cycles = 0, n;
    always #5 clk = ~clk;
    iss_init_sync_sequencer uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .primary_sync_input_n, .secondary_sync_input_n, .sync_out_n,
        .sync_out_oe, .chip_reset, .data_out_en, .block_hold);
    iss_sync_gen u_gen (.clk, .hold_low, .pulse, .primary_sync_input_n, .secondary_sync_input_n);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // returns in the cycle where write effects first show
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata);
    endtask : rd
    task automatic t_standalone;
        rd(8'h00, 16'hff00);
        rd(8'h02, 16'h0000);
        wr(8'h00, 16'hff00);
        chk("chip reset", 16'h0001, 16'(chip_reset));
        wr(8'h03, 16'h01ff);
        chk("enables", 16'h01ff, {7'h00, sync_out_oe, data_out_en});
        wr(8'h03, 16'h0000);
        chk("enables", 16'h0000, {7'h00, sync_out_oe, data_out_en});
        wr(8'h01, 16'h0004);
        wr(8'h04, 16'h4924);
        wr(8'h00, 16'h0100);
        chk("chip reset", 16'h0000, 16'(chip_reset));
        tick(2);
        chk("hold", 16'h0000, 16'(block_hold));
        wr(8'h01, 16'h0004);
        chk("sync out", 16'h0000, 16'(sync_out_n));
        tick(1);
        chk("sync out", 16'h0001, 16'(sync_out_n));
        rd(8'h04, 16'h4924);
        wr(8'h01, 16'h0008);
        chk("hold", 16'h000f, 16'(block_hold));
        wr(8'h01, 16'h0000);
        chk("hold", 16'h0000, 16'(block_hold));
        $display("standalone test done");
    endtask : t_standalone
    task automatic t_master;
        wr(8'h00, 16'hff00);
        chk("chip reset", 16'h0001, 16'(chip_reset));
        wr(8'h03, 16'h0100);
        chk("enables", 16'h0100, {7'h00, sync_out_oe, data_out_en});
        rd(8'h03, 16'h0100);
        wr(8'h01, 16'h0004);
        wr(8'h04, 16'h2494);
        wr(8'h00, 16'h0100);
        tick(2);
        wr(8'h01, 16'h0014);
        chk("sync out", 16'h0000, 16'(sync_out_n));
        tick(1);
        chk("sync out", 16'h0001, 16'(sync_out_n));
        rd(8'h01, 16'h0014);
        $display("master test done");
    endtask : t_master
    task automatic t_external;
        wr(8'h00, 16'hff00);
        wr(8'h03, 16'h0100);
        // drop the force bit that the master scenario left behind
        wr(8'h01, 16'h0000);
        hold_low <= 1'b1;
        wr(8'h04, 16'h2492);
        wr(8'h00, 16'h0100);
        tick(6);
        chk("hold", 16'h000f, 16'(block_hold));
        chk("sync out", 16'h0000, 16'(sync_out_n));
        hold_low <= 1'b0;
        tick(7);
        chk("hold", 16'h0000, 16'(block_hold));
        pulse <= 1'b1;
        tick(1);
        pulse <= 1'b0;
        n = 0;
        repeat (8) begin
            tick(1);
            n += int'(block_hold[0] === 1'b1);
        end
        chk("hold cycles", 16'h0001, 16'(n));
        $display("external sync test done");
    endtask : t_external
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // ceiling well above the roughly 100 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        tick(3);
        chk("reset outputs", 16'h0003, {14'h0000, chip_reset, sync_out_n});
        @(posedge clk);
        rst_n <= 1'b1;
        t_standalone();
        t_master();
        t_external();
        test_done();
    end
endmodule : iss_init_sync_sequencer_tb
